// ### hw/mms_defines.svh
// What this block does
// RL1: program, data and stack spaces never alias
// RL2: 12-bit program counter reaches 4K bytes
// RL3: program space holds code, operands, vectors
// RL4: return stack is six 12-bit entries
// RL5: 64-byte data region reads program memory
// RL6: data space maps RAM and core registers
// RL7: protection bit blocks external program reads
// RL8: only full erase clears protection and contents; here srst_i also clears protection
// RL9: window at 0040h-007Fh reaches 0000h-0FFFh
// RL10: window select bits form upper address
// RL11: software writes window select before use
// RL12: stack is LIFO for call, interrupt, return; here there is no interrupt push, only PC_CALL pushes
// RL13: writes into window leave program memory alone
`ifndef MMS_DEFINES_SVH
`define MMS_DEFINES_SVH

`define MMS_PC_W        12
`define MMS_ROM_DEPTH   4096
`define MMS_DATA_W      8
`define MMS_DADDR_W     8
`define MMS_STACK_DEPTH 6
`define MMS_WSEL_W      6
`define MMS_RAM_DEPTH   64
`define MMS_RAM_AW      6
`define MMS_PC_ONE      12'h001
`define MMS_PC_LAST     12'hfff
`define MMS_PC_RESET    12'h000
`define MMS_ZERO_BYTE   8'h00
`define MMS_ERASED_BYTE 8'h00
`define MMS_WIN_BASE    8'h40
`define MMS_WIN_LAST    8'h7f
`define MMS_RAM_BASE    8'h84
`define MMS_RAM_LAST    8'hbf
`define MMS_ADDR_X      8'h80
`define MMS_ADDR_Y      8'h81
`define MMS_ADDR_V      8'h82
`define MMS_ADDR_W      8'h83
`define MMS_ADDR_IOR    8'hc8
`define MMS_ADDR_WSEL   8'hc9
`define MMS_ADDR_ACC    8'hff
`define MMS_PERIPH_BASE 8'hc0

`endif

// ### hw/mms_mem.sv
`timescale 1ns/1ps
// byte memory, one write port, two registered read ports
module mms_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  input  wire logic          clk_sys_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] ra_addr_i,
  output logic      [7:0]    ra_data_o,
  input  wire logic [AW-1:0] rb_addr_i,
  output logic      [7:0]    rb_data_o
);
  logic [7:0] mem [DEPTH];

  // contents have no reset; read data is registered
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    ra_data_o <= mem[ra_addr_i];
    rb_data_o <= mem[rb_addr_i];
  end
endmodule

// ### hw/mms_memory_map.sv
`timescale 1ns/1ps
`include "mms_defines.svh"
module mms_memory_map #(
  parameter bit ERASABLE = 1'b1
) (
  input  wire logic                     clk_sys_i,
  input  wire logic                     srst_i,
  input  wire mms_pkg::mms_pc_op_e      pc_op_i,
  input  wire logic [`MMS_PC_W-1:0]     pc_target_i,
  input  wire logic                     fetch_req_i,
  input  wire logic                     data_req_i,
  input  wire mms_pkg::mms_dreq_s       data_i,
  input  wire logic [7:0]               periph_rdata_i,
  input  wire logic                     prog_mode_i,
  input  wire logic                     ext_rd_i,
  input  wire logic                     ext_wr_i,
  input  wire logic [`MMS_PC_W-1:0]     ext_addr_i,
  input  wire logic [7:0]               ext_wdata_i,
  input  wire logic                     protect_set_i,
  input  wire logic                     erase_req_i,
  output logic [`MMS_PC_W-1:0]          program_counter_o,
  output logic [7:0]                    fetch_data_o,
  output logic                          fetch_valid_o,
  output logic [7:0]                    data_rdata_o,
  output logic                          data_rvalid_o,
  output mms_pkg::mms_dreq_s            periph_req_o,
  output logic                          periph_stb_o,
  output logic [7:0]                    ext_rdata_o,
  output logic                          ext_rvalid_o,
  output logic                          ext_blocked_o,
  output logic                          protect_o,
  output logic                          erase_busy_o
);
  function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // program counter and return stack
  logic [`MMS_PC_W-1:0] pc_q, pc_d;
  logic [`MMS_PC_W-1:0] stk_q [`MMS_STACK_DEPTH];
  logic [`MMS_PC_W-1:0] stk_d [`MMS_STACK_DEPTH];
  // shift stack: push drops the deepest entry, pop refills with the last
  always_comb begin
    pc_d = pc_q;
    stk_d = stk_q;
    case (pc_op_i)
      mms_pkg::PC_INCR: pc_d = pc_q + `MMS_PC_ONE; // [RL2]
      mms_pkg::PC_JUMP: pc_d = pc_target_i;
      mms_pkg::PC_CALL: begin
        pc_d = pc_target_i;
        stk_d[0] = pc_q; // [RL12] [RL4]
        for (int i = 1; i < `MMS_STACK_DEPTH; i++) stk_d[i] = stk_q[i-1];
      end
      mms_pkg::PC_RET: begin
        pc_d = stk_q[0]; // [RL12]
        for (int i = 0; i < `MMS_STACK_DEPTH - 1; i++) stk_d[i] = stk_q[i+1];
      end
      default: pc_d = pc_q;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pc_q <= `MMS_PC_RESET;
      for (int i = 0; i < `MMS_STACK_DEPTH; i++) stk_q[i] <= `MMS_PC_RESET;
    end else begin
      pc_q <= pc_d;
      stk_q <= stk_d;
    end
  end

  // core registers and window select live in data space
  logic [7:0] acc_q, acc_d, x_q, x_d, y_q, y_d, v_q, v_d, w_q, w_d, ior_q, ior_d;
  logic [`MMS_WSEL_W-1:0] wsel_q, wsel_d;
  logic       is_win, is_ram, is_reg, is_per;
  logic [7:0] reg_val, ram_off;
  logic       ram_we;
  mms_pkg::mms_src_e src_d;
  always_comb begin
    is_win = in_rng(data_i.addr, `MMS_WIN_BASE, `MMS_WIN_LAST); // [RL9] [RL5]
    is_ram = in_rng(data_i.addr, `MMS_RAM_BASE, `MMS_RAM_LAST); // [RL6]
    is_reg = 1'b1;
    reg_val = `MMS_ZERO_BYTE;
    acc_d = acc_q; x_d = x_q; y_d = y_q; v_d = v_q; w_d = w_q;
    ior_d = ior_q;
    wsel_d = wsel_q;
    // write-only registers read as zero: software must not read them [RL11]
    case (data_i.addr)
      `MMS_ADDR_X:    reg_val = x_q;
      `MMS_ADDR_Y:    reg_val = y_q;
      `MMS_ADDR_V:    reg_val = v_q;
      `MMS_ADDR_W:    reg_val = w_q;
      `MMS_ADDR_ACC:  reg_val = acc_q;
      `MMS_ADDR_IOR:  reg_val = `MMS_ZERO_BYTE;
      `MMS_ADDR_WSEL: reg_val = `MMS_ZERO_BYTE;
      default:        is_reg = 1'b0;
    endcase
    is_per = !is_reg && (data_i.addr >= `MMS_PERIPH_BASE) && (data_i.addr != `MMS_ADDR_ACC);
    if (data_req_i && data_i.wr) begin // [RL6]
      case (data_i.addr)
        `MMS_ADDR_X:    x_d = data_i.wdata;
        `MMS_ADDR_Y:    y_d = data_i.wdata;
        `MMS_ADDR_V:    v_d = data_i.wdata;
        `MMS_ADDR_W:    w_d = data_i.wdata;
        `MMS_ADDR_ACC:  acc_d = data_i.wdata;
        `MMS_ADDR_IOR:  ior_d = data_i.wdata;
        `MMS_ADDR_WSEL: wsel_d = data_i.wdata[`MMS_WSEL_W-1:0];
        default:        ;
      endcase
    end
    ram_we = data_req_i && data_i.wr && is_ram;
    ram_off = data_i.addr - `MMS_RAM_BASE; // only the low bits index the ram
    // window reads only while the core owns the second rom port [RL1]
    if (is_win && !prog_mode_i) src_d = mms_pkg::SRC_ROM;
    else if (is_ram)            src_d = mms_pkg::SRC_RAM;
    else if (is_reg || is_per)  src_d = mms_pkg::SRC_REG;
    else                        src_d = mms_pkg::SRC_ZERO;
  end
  // peripheral data is sampled in the strobe cycle
  logic [7:0] regv_q, regv_d;
  logic       rd_q1;
  logic       per_rd_q;
  mms_pkg::mms_src_e src_q;
  assign regv_d = is_reg ? reg_val : `MMS_ZERO_BYTE;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      acc_q <= `MMS_ZERO_BYTE; x_q <= `MMS_ZERO_BYTE; y_q <= `MMS_ZERO_BYTE;
      v_q <= `MMS_ZERO_BYTE; w_q <= `MMS_ZERO_BYTE; ior_q <= `MMS_ZERO_BYTE;
      wsel_q <= '0;
      regv_q <= `MMS_ZERO_BYTE;
      src_q <= mms_pkg::SRC_ZERO;
      rd_q1 <= 1'b0;
      per_rd_q <= 1'b0;
      periph_stb_o <= 1'b0;
      periph_req_o <= '0;
    end else begin
      acc_q <= acc_d; x_q <= x_d; y_q <= y_d; v_q <= v_d; w_q <= w_d;
      ior_q <= ior_d;
      wsel_q <= wsel_d;
      regv_q <= regv_d;
      src_q <= src_d;
      rd_q1 <= data_req_i && !data_i.wr;
      per_rd_q <= data_req_i && !data_i.wr && is_per;
      periph_stb_o <= data_req_i && is_per;
      periph_req_o <= data_i;
    end
  end
  // program array address paths [RL10]
  logic [`MMS_PC_W-1:0] win_addr, rb_addr, rom_waddr;
  logic [7:0]           rom_a, rom_b, ram_a, rom_wdata;
  logic                 rom_we;
  logic [`MMS_PC_W-1:0] ers_q, ers_d;
  mms_pkg::mms_st_e     st_q, st_d;
  logic                 prot_q, prot_d;
  assign win_addr = {wsel_q, data_i.addr[`MMS_RAM_AW-1:0]}; // [RL10] [RL9]
  assign rb_addr  = prog_mode_i ? ext_addr_i : win_addr;

  // erase sweeps the whole array, then drops protection [RL8]
  always_comb begin
    st_d = st_q;
    ers_d = ers_q;
    prot_d = prot_q;
    rom_we = 1'b0;
    rom_waddr = ext_addr_i;
    rom_wdata = ext_wdata_i;
    case (st_q)
      mms_pkg::ST_IDLE: begin
        if (protect_set_i) prot_d = 1'b1; // [RL7]
        if (ERASABLE && erase_req_i) begin
          st_d = mms_pkg::ST_ERASE;
          ers_d = `MMS_PC_RESET;
        end else if (prog_mode_i && ext_wr_i) begin
          rom_we = 1'b1; // window writes never reach here [RL13]
        end
      end
      mms_pkg::ST_ERASE: begin
        rom_we = 1'b1;
        rom_waddr = ers_q;
        rom_wdata = `MMS_ERASED_BYTE;
        ers_d = ers_q + `MMS_PC_ONE;
        if (ers_q == `MMS_PC_LAST) begin
          st_d = mms_pkg::ST_IDLE;
          prot_d = 1'b0; // [RL8]
        end
      end
      default: st_d = mms_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      st_q <= mms_pkg::ST_IDLE;
      ers_q <= `MMS_PC_RESET;
      prot_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ers_q <= ers_d;
      prot_q <= prot_d;
    end
  end

  // program array: port a fetches, port b serves window or programmer [RL3]
  mms_mem #(.DEPTH(`MMS_ROM_DEPTH), .AW(`MMS_PC_W)) u_rom (
    .clk_sys_i (clk_sys_i),
    .we_i      (rom_we),
    .waddr_i   (rom_waddr),
    .wdata_i   (rom_wdata),
    .ra_addr_i (pc_q),
    .ra_data_o (rom_a),
    .rb_addr_i (rb_addr),
    .rb_data_o (rom_b)
  );
  // user ram, separate from the program array [RL1]
  mms_mem #(.DEPTH(`MMS_RAM_DEPTH), .AW(`MMS_RAM_AW)) u_ram (
    .clk_sys_i (clk_sys_i),
    .we_i      (ram_we),
    .waddr_i   (ram_off[`MMS_RAM_AW-1:0]),
    .wdata_i   (data_i.wdata),
    .ra_addr_i (ram_off[`MMS_RAM_AW-1:0]),
    .ra_data_o (ram_a),
    .rb_addr_i (ram_off[`MMS_RAM_AW-1:0]),
    .rb_data_o ()
  );
  // output stage: every answer lands two edges after its request
  logic [7:0] rdata_d;
  logic       f_q1, x_q1, xblk_q1;
  always_comb begin
    case (src_q)
      mms_pkg::SRC_ROM: rdata_d = rom_b; // [RL5]
      mms_pkg::SRC_RAM: rdata_d = ram_a;
      mms_pkg::SRC_REG: rdata_d = per_rd_q ? periph_rdata_i : regv_q;
      default:          rdata_d = `MMS_ZERO_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      f_q1 <= 1'b0; x_q1 <= 1'b0; xblk_q1 <= 1'b0;
      fetch_valid_o <= 1'b0; fetch_data_o <= `MMS_ZERO_BYTE;
      data_rvalid_o <= 1'b0; data_rdata_o <= `MMS_ZERO_BYTE;
      ext_rvalid_o <= 1'b0; ext_rdata_o <= `MMS_ZERO_BYTE; ext_blocked_o <= 1'b0;
      program_counter_o <= `MMS_PC_RESET;
      protect_o <= 1'b0; erase_busy_o <= 1'b0;
    end else begin
      f_q1 <= fetch_req_i;
      x_q1 <= prog_mode_i && ext_rd_i;
      xblk_q1 <= prog_mode_i && ext_rd_i && prot_q;
      fetch_valid_o <= f_q1;
      fetch_data_o <= rom_a;
      data_rvalid_o <= rd_q1;
      data_rdata_o <= rd_q1 ? rdata_d : `MMS_ZERO_BYTE;
      ext_rvalid_o <= x_q1;
      ext_blocked_o <= xblk_q1;
      ext_rdata_o <= (x_q1 && !xblk_q1) ? rom_b : `MMS_ZERO_BYTE; // [RL7]
      program_counter_o <= pc_d;
      protect_o <= prot_d;
      erase_busy_o <= (st_d == mms_pkg::ST_ERASE);
    end
  end
  a_pc_incr: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL2]
    pc_op_i == mms_pkg::PC_INCR |=> pc_q == $past(pc_q) + `MMS_PC_ONE)
    else $error("pc did not increment");
  a_call_ret: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL12]
    (pc_op_i == mms_pkg::PC_CALL) ##1 (pc_op_i == mms_pkg::PC_RET)
    |=> pc_q == $past(pc_q, 2))
    else $error("return did not restore caller address");
  a_stack_shift: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL4]
    pc_op_i == mms_pkg::PC_CALL |=> stk_q[5] == $past(stk_q[4]))
    else $error("stack did not shift on push");
  a_win_addr: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL10]
    data_req_i && is_win && !prog_mode_i |-> rb_addr[5:0] == data_i.addr[5:0]
    && rb_addr[11:6] == wsel_q)
    else $error("window address wrong");
  a_win_read: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL5]
    data_req_i && !data_i.wr && is_win && !prog_mode_i
    |=> ##1 data_rvalid_o && data_rdata_o == $past(rom_b, 1))
    else $error("window read did not return program byte");
  a_win_nowrite: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL13]
    data_req_i && data_i.wr && is_win && !prog_mode_i && st_q == mms_pkg::ST_IDLE
    |-> !rom_we && !ram_we)
    else $error("window write reached memory");
  a_wsel_write: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL6]
    data_req_i && data_i.wr && data_i.addr == `MMS_ADDR_WSEL
    |=> wsel_q == $past(data_i.wdata[5:0]))
    else $error("window select not written");
  a_prot_block: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL7]
    prog_mode_i && ext_rd_i && prot_q |-> ##2 ext_blocked_o && ext_rdata_o == 8'h00)
    else $error("protected read leaked data");
  a_erase_clear: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL8]
    $fell(prot_q) |-> $past(st_q) == mms_pkg::ST_ERASE && $past(ers_q) == `MMS_PC_LAST)
    else $error("protection cleared without full erase");
  a_space_sep: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RL1]
    data_req_i && (data_i.addr < `MMS_RAM_BASE || data_i.addr > `MMS_RAM_LAST) |-> !ram_we)
    else $error("data write outside ram hit ram");
endmodule

// ### hw/mms_pkg.sv
package mms_pkg;

  // one data-space request from the core
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } mms_dreq_s;

  // program counter operations
  typedef enum logic [4:0] {
    PC_HOLD = 5'b00001,
    PC_INCR = 5'b00010,
    PC_JUMP = 5'b00100,
    PC_CALL = 5'b01000,
    PC_RET  = 5'b10000
  } mms_pc_op_e;

  // source of a pending data read
  typedef enum logic [3:0] {
    SRC_ZERO = 4'b0001,
    SRC_ROM  = 4'b0010,
    SRC_RAM  = 4'b0100,
    SRC_REG  = 4'b1000
  } mms_src_e;

  // erase sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ERASE = 2'b10
  } mms_st_e;

endpackage

// ### test/mcu_memory_space_map_test.sv
`timescale 1ns/1ps
module mcu_memory_space_map_test;
  logic                clk_sys_i = 1'b0;
  logic                srst_i    = 1'b1;
  mms_pkg::mms_pc_op_e pc_op     = mms_pkg::PC_HOLD;
  mms_pkg::mms_dreq_s  dreq      = '0;
  mms_pkg::mms_dreq_s  preq;
  logic [11:0]         pc_tgt    = 12'h000;
  logic [11:0]         xaddr     = 12'h000;
  logic [11:0]         pc;
  logic [7:0]          xwdata    = 8'h00;
  logic [7:0]          prd, fdata, rdata, xrdata;
  logic                fetch_req = 1'b0;
  logic                data_req  = 1'b0;
  logic                prog_mode = 1'b0;
  logic                xrd       = 1'b0;
  logic                xwr       = 1'b0;
  logic                prot_set  = 1'b0;
  logic                erase_req = 1'b0;
  logic                fvalid, rvalid, pstb, xvalid, xblk, prot, busy;
  logic [7:0]          rom [4096];
  logic [11:0]         addrs [16];
  logic [11:0]         stk [$];
  logic [11:0]         pcm;
  logic [7:0]          v;
  int                  seed = 32'h8406;
  int                  n_mismatch = 0;
  int                  n_tests = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  mms_memory_map i_mms_memory_map (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .pc_op_i(pc_op),
    .pc_target_i(pc_tgt), .fetch_req_i(fetch_req), .data_req_i(data_req), .data_i(dreq),
    .periph_rdata_i(prd), .prog_mode_i(prog_mode), .ext_rd_i(xrd), .ext_wr_i(xwr),
    .ext_addr_i(xaddr), .ext_wdata_i(xwdata), .protect_set_i(prot_set),
    .erase_req_i(erase_req), .program_counter_o(pc), .fetch_data_o(fdata),
    .fetch_valid_o(fvalid), .data_rdata_o(rdata), .data_rvalid_o(rvalid),
    .periph_req_o(preq), .periph_stb_o(pstb), .ext_rdata_o(xrdata), .ext_rvalid_o(xvalid),
    .ext_blocked_o(xblk), .protect_o(prot), .erase_busy_o(busy));

  mms_periph_model i_mms_periph_model (.clk_sys_i(clk_sys_i), .periph_req_i(preq),
    .periph_stb_i(pstb), .periph_rdata_o(prd));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // one data access; read answer stands one cycle, two edges after the request
  task automatic dacc(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [7:0] exp);
    dreq     = '{a, w, d};
    data_req = 1'b1;
    step(1);
    data_req = 1'b0;
    step(1);
    if (!w) begin
      chk({15'h0, rvalid}, 16'h1);
      chk({8'h0, rdata}, {8'h0, exp});
    end
  endtask

  task automatic xw(input logic [11:0] a, input logic [7:0] d);
    xaddr  = a;
    xwdata = d;
    xwr    = 1'b1;
    step(1);
    xwr    = 1'b0;
    step(1); // idle edge so the next strobe is not raised in the same step
  endtask

  task automatic xr(input logic [11:0] a, input logic [7:0] exp, input logic blk);
    xaddr = a;
    xrd   = 1'b1;
    step(1);
    xrd   = 1'b0;
    step(1);
    chk({15'h0, xvalid}, 16'h1);
    chk({7'h0, xblk, xrdata}, {7'h0, blk, exp});
  endtask

  // pc operation stays on until the next one, so call and return run back to back
  task automatic pcop(input mms_pkg::mms_pc_op_e op, input logic [11:0] t);
    pc_op  = op;
    pc_tgt = t;
    step(1);
  endtask

  task automatic final_report();
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: whole run is about 4400 cycles
  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end

  initial begin
    step(8);
    srst_i = 1'b0;
    // load the program array from the programmer side, corners first
    prog_mode = 1'b1;
    for (int i = 0; i < 16; i++) begin
      addrs[i] = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
      v = 8'($random(seed));
      rom[addrs[i]] = v;
      xw(addrs[i], v);
    end
    foreach (addrs[i]) xr(addrs[i], rom[addrs[i]], 1'b0);
    // window reads through every programmed block, stray writes ignored
    prog_mode = 1'b0;
    foreach (addrs[i]) begin
      dacc(8'hc9, 1'b1, {2'b00, addrs[i][11:6]}, 8'h00);
      dacc({2'b01, addrs[i][5:0]}, 1'b0, 8'h00, rom[addrs[i]]);
      dacc({2'b01, addrs[i][5:0]}, 1'b1, ~rom[addrs[i]], 8'h00);
      dacc({2'b01, addrs[i][5:0]}, 1'b0, 8'h00, rom[addrs[i]]);
    end
    // jump and fetch at the first four programmed addresses
    for (int i = 0; i < 4; i++) begin
      pcop(mms_pkg::PC_JUMP, addrs[i]);
      chk({4'h0, pc}, {4'h0, addrs[i]});
      fetch_req = 1'b1;
      step(1);
      fetch_req = 1'b0;
      step(1);
      chk({7'h0, fvalid, fdata}, {7'h0, 1'b1, rom[addrs[i]]});
    end
    pcm = addrs[3];
    pcop(mms_pkg::PC_INCR, 12'h000);
    chk({4'h0, pc}, {4'h0, pcm + 12'h001});
    pcm = pcm + 12'h001;
    // six nested calls then six returns
    for (int i = 0; i < 6; i++) begin
      stk.push_back(pcm);
      pcm = 12'($random(seed));
      pcop(mms_pkg::PC_CALL, pcm);
      chk({4'h0, pc}, {4'h0, pcm});
    end
    for (int i = 0; i < 6; i++) begin
      pcop(mms_pkg::PC_RET, 12'h000);
      chk({4'h0, pc}, {4'h0, stk.pop_back()});
    end
    pc_op = mms_pkg::PC_HOLD;
    // core registers, ram corners, peripheral, write-only and unmapped places
    dacc(8'h84, 1'b1, 8'ha5, 8'h00);
    dacc(8'hbf, 1'b1, 8'h3c, 8'h00);
    dacc(8'h80, 1'b1, 8'h71, 8'h00);
    dacc(8'h83, 1'b1, 8'h0e, 8'h00);
    dacc(8'hff, 1'b1, 8'hd2, 8'h00);
    dacc(8'hc8, 1'b1, 8'h5f, 8'h00);
    dacc(8'h84, 1'b0, 8'h00, 8'ha5);
    dacc(8'hbf, 1'b0, 8'h00, 8'h3c);
    dacc(8'h80, 1'b0, 8'h00, 8'h71);
    dacc(8'h83, 1'b0, 8'h00, 8'h0e);
    dacc(8'hff, 1'b0, 8'h00, 8'hd2);
    dacc(8'hc8, 1'b0, 8'h00, 8'h00);
    dacc(8'hc9, 1'b0, 8'h00, 8'h00);
    dacc(8'hc0, 1'b0, 8'h00, 8'h9a);
    dacc(8'h00, 1'b0, 8'h00, 8'h00);
    // program byte at the ram's number must not reach the ram
    prog_mode = 1'b1;
    xw(12'h084, 8'h11);
    prog_mode = 1'b0;
    dacc(8'h84, 1'b0, 8'h00, 8'ha5);
    // protection blocks readout until a full erase
    prog_mode = 1'b1;
    prot_set  = 1'b1;
    step(1);
    prot_set  = 1'b0;
    step(2);
    chk({15'h0, prot}, 16'h1);
    xr(addrs[2], 8'h00, 1'b1);
    erase_req = 1'b1;
    step(1);
    erase_req = 1'b0;
    step(1);
    chk({15'h0, busy}, 16'h1);
    for (int k = 0; k < 5000 && busy; k++) step(1);
    step(2);
    chk({14'h0, busy, prot}, 16'h0);
    xr(addrs[2], 8'h00, 1'b0);
    xr(12'h084, 8'h00, 1'b0);
    final_report();
  end
endmodule

// ### test/mms_periph_model.sv
`timescale 1ns/1ps
// peripheral registers as seen from the core's forwarded data bus
module mms_periph_model (
  input  wire logic               clk_sys_i,
  input  wire mms_pkg::mms_dreq_s periph_req_i,
  input  wire logic               periph_stb_i,
  output logic [7:0]              periph_rdata_o
);
  logic [7:0] junk_q = 8'h3c;

  // bus toggles when not strobed, so stale data never passes as a match
  always_ff @(posedge clk_sys_i) begin
    junk_q <= ~junk_q;
  end

  // answer is a fixed function of the address, only while strobed
  assign periph_rdata_o = periph_stb_i ? (periph_req_i.addr ^ 8'h5a) : junk_q;
endmodule
